// ===== eip_cfg.svh
// register offsets, field positions and reset values of the external interrupt pin
`ifndef EIP_CFG_SVH
`define EIP_CFG_SVH

// register indices; byte address is four times the index
`define EIP_IDX_OPT2      6'h1E
`define EIP_IDX_ISC       6'h1D
`define EIP_IDX_BRK       6'h1F
`define EIP_IDX_EVT       6'h20
`define EIP_IDX_EVM       6'h21

// system_option_two fields
`define EIP_OPT_PUD       1
`define EIP_OPT_EN        0
`define EIP_OPT_RST       8'h00
`define EIP_OPT_EN_RST    1'b0

// interrupt_status_control fields
`define EIP_ISC_PEND      3
`define EIP_ISC_ACK       2
`define EIP_ISC_MASK      1
`define EIP_ISC_MODE      0

// break_flag_control field
`define EIP_BRK_CLREN     0

// event status / event mask fields
`define EIP_EVT_LATCH     0
`define EIP_EVT_BLOCK     1
`define EIP_EVT_W         2

// vector pair of this interrupt
`define EIP_VEC_HI        16'hFFFA
`define EIP_VEC_LO        16'hFFFB

// bus answers
`define EIP_RESP_OKAY     2'h0
`define EIP_RESP_SLVERR   2'h2

`endif

// ===== eip_pkg.sv
// types shared by the external interrupt pin block
package eip_pkg;

    // software-held control state of the block
    typedef struct packed {
        logic funcEn;
        logic pullupDis;
        logic reqMask;
        logic levelMode;
        logic breakClrEn;
    } eip_ctl_s;

    // captured write request
    typedef struct packed {
        logic [5:0]  idx;
        logic [31:0] data;
        logic [3:0]  strb;
    } eip_wreq_s;

endpackage : eip_pkg

// ===== eip_top.sv
// external interrupt pin latch with AXI4-Lite register access
//
// How it works
// - Function enable bit zero frees the shared pin and stops the pin from setting the latch.
// - A low pin level can set the interrupt latch, raising a request.
// - A vector fetch for this interrupt acknowledges and clears its latch.
// - Writing one to the acknowledge bit clears the latch.
// - Acknowledge bit is write-only, reads zero, cleared by reset.
// - Reset clears latch and sensitivity bit even with pin held low.
// - Sensitivity zero: only falling edges set; acknowledge clears at once.
// - Sensitivity one: stays pending until acknowledged and pin back high.
// - A falling edge after a software acknowledge latches a new request.
// - Mask set withholds the request; mask is read/write, reset clear.
// - Pending flag reads the latch state regardless of the mask.
// - Taken request makes the CPU fetch its vector at FFFA/FFFB.
// - With the function disabled branch-on-pin instructions see a one.
// - Pullup is on by default; the pullup-disable bit removes it.
// - Break clear-enable one lets software clear the latch in break.
// - Break clear-enable zero makes acknowledge writes in break ineffective.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "eip_cfg.svh"

module eip_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              extIntPin_n,
    input  wire logic              vectorFetch,
    input  wire logic              breakState,
    output logic                   cpuIrqReq,
    output logic [15:0]            vectorAddr,
    output logic                   branchPinLevel,
    output logic                   pullupEnable,
    output logic                   pinIsIntFunction,
    output logic                   irqOut
);

    // ****************************************************************
    // state
    // ****************************************************************
    eip_pkg::eip_ctl_s    ctl_reg;
    eip_pkg::eip_wreq_s   wreq_reg;
    logic                 awHeld_reg;
    logic                 wHeld_reg;
    logic                 pinSync1_reg;
    logic                 pinSync2_reg;
    logic                 effPrev_reg;
    logic                 latch_reg;
    logic                 latch_next;
    logic                 ackSeen_reg;
    logic [`EIP_EVT_W-1:0] evtStat_reg;
    logic [`EIP_EVT_W-1:0] evtMask_reg;
    logic [`EIP_EVT_W-1:0] evtSet;
    logic                 doWrite;
    logic                 wrIsc;
    logic                 wrOpt;
    logic                 wrBrk;
    logic                 wrEvt;
    logic                 wrEvm;
    logic                 wrHit;
    logic                 swAckReq;
    logic                 swAck;
    logic                 anyAck;
    logic                 effLvl;
    logic                 fallEdge;
    logic                 levelSet;
    logic [5:0]           rdIdx;
    logic [31:0]          rdData;
    logic                 rdHit;

    // ****************************************************************
    // write channel capture
    // ****************************************************************

    // address and data are taken independently, in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            wreq_reg      <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg    <= 1'b1;
                s_axi_awready <= 1'b0;
                wreq_reg.idx  <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg     <= 1'b1;
                s_axi_wready  <= 1'b0;
                wreq_reg.data <= s_axi_wdata;
                wreq_reg.strb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_reg    <= 1'b0;
                wHeld_reg     <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // write happens once both halves are in and the old answer is gone
    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wrOpt   = wreq_reg.idx == `EIP_IDX_OPT2;
    assign wrIsc   = wreq_reg.idx == `EIP_IDX_ISC;
    assign wrBrk   = wreq_reg.idx == `EIP_IDX_BRK;
    assign wrEvt   = wreq_reg.idx == `EIP_IDX_EVT;
    assign wrEvm   = wreq_reg.idx == `EIP_IDX_EVM;
    assign wrHit   = wrOpt || wrIsc || wrBrk || wrEvt || wrEvm;

    // write response; unmapped addresses answer SLVERR
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EIP_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? `EIP_RESP_OKAY : `EIP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************

    // only byte lane 0 carries the 8-bit registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_reg.funcEn     <= `EIP_OPT_EN_RST;
            ctl_reg.pullupDis  <= 1'b0;
            ctl_reg.reqMask    <= 1'b0;
            ctl_reg.levelMode  <= 1'b0;
            ctl_reg.breakClrEn <= 1'b0;
        end else if (doWrite && wreq_reg.strb[0]) begin
            if (wrOpt) begin
                ctl_reg.funcEn    <= wreq_reg.data[`EIP_OPT_EN];
                ctl_reg.pullupDis <= wreq_reg.data[`EIP_OPT_PUD];
            end
            if (wrIsc) begin
                ctl_reg.reqMask   <= wreq_reg.data[`EIP_ISC_MASK];
                ctl_reg.levelMode <= wreq_reg.data[`EIP_ISC_MODE];
            end
            if (wrBrk) begin
                ctl_reg.breakClrEn <= wreq_reg.data[`EIP_BRK_CLREN];
            end
        end
    end

    // ****************************************************************
    // pin synchroniser and detection
    // ****************************************************************

    // two flops before any decision; metastability stays out of the latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinSync1_reg <= 1'b1;
            pinSync2_reg <= 1'b1;
            effPrev_reg  <= 1'b1;
        end else begin
            pinSync1_reg <= extIntPin_n;
            pinSync2_reg <= pinSync1_reg;
            effPrev_reg  <= effLvl;
        end
    end

    // a disabled function looks like a pin held high
    assign effLvl   = pinSync2_reg || !ctl_reg.funcEn;
    assign fallEdge = effPrev_reg && !effLvl;
    assign levelSet = ctl_reg.levelMode && !effLvl;

    // ****************************************************************
    // acknowledge and latch
    // ****************************************************************

    // acknowledge bit is never stored, so it always reads back zero
    assign swAckReq = doWrite && wrIsc && wreq_reg.strb[0]
                      && wreq_reg.data[`EIP_ISC_ACK];
    // break protects the latch unless clearing is allowed
    assign swAck  = swAckReq && (!breakState || ctl_reg.breakClrEn);
    assign anyAck = swAck || vectorFetch;

    // set beats clear, so an edge in the same cycle as an ack is kept
    always_comb begin
        if (fallEdge || levelSet) begin
            latch_next = 1'b1;
        end else if (!ctl_reg.levelMode) begin
            latch_next = latch_reg && !anyAck;
        end else begin
            latch_next = latch_reg && !(anyAck || ackSeen_reg);
        end
    end

    // latch and remembered acknowledge for level mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_reg   <= 1'b0;
            ackSeen_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            if (!latch_next || fallEdge) begin
                ackSeen_reg <= 1'b0;
            end else if (anyAck) begin
                ackSeen_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // outputs toward the CPU and the pin
    // ****************************************************************

    // request to priority logic, vector pair, branch level and pin control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpuIrqReq        <= 1'b0;
            vectorAddr       <= `EIP_VEC_HI;
            branchPinLevel   <= 1'b1;
            pullupEnable     <= 1'b1;
            pinIsIntFunction <= 1'b0;
        end else begin
            cpuIrqReq        <= latch_reg && !ctl_reg.reqMask;
            vectorAddr       <= `EIP_VEC_HI;
            branchPinLevel   <= effLvl;
            pullupEnable     <= !ctl_reg.pullupDis;
            pinIsIntFunction <= ctl_reg.funcEn;
        end
    end

    // ****************************************************************
    // event status, mask and system interrupt
    // ****************************************************************

    // events: latch newly set, acknowledge refused in break
    assign evtSet[`EIP_EVT_LATCH] = latch_next && !latch_reg;
    assign evtSet[`EIP_EVT_BLOCK] = swAckReq && !swAck;

    // write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evtStat_reg <= '0;
            evtMask_reg <= '0;
        end else begin
            if (doWrite && wrEvt && wreq_reg.strb[0]) begin
                evtStat_reg <= (evtStat_reg
                    & ~wreq_reg.data[`EIP_EVT_W-1:0]) | evtSet;
            end else begin
                evtStat_reg <= evtStat_reg | evtSet;
            end
            if (doWrite && wrEvm && wreq_reg.strb[0]) begin
                evtMask_reg <= wreq_reg.data[`EIP_EVT_W-1:0];
            end
        end
    end

    // level output, one flop behind the status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |(evtStat_reg & evtMask_reg);
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************

    // read mux; pending flag shows the latch, unaffected by the mask
    assign rdIdx = s_axi_araddr[7:2];
    always_comb begin
        rdData = '0;
        rdHit  = 1'b1;
        case (rdIdx)
            `EIP_IDX_OPT2: begin
                rdData[`EIP_OPT_EN]  = ctl_reg.funcEn;
                rdData[`EIP_OPT_PUD] = ctl_reg.pullupDis;
            end
            `EIP_IDX_ISC: begin
                rdData[`EIP_ISC_PEND] = latch_reg;
                rdData[`EIP_ISC_MASK] = ctl_reg.reqMask;
                rdData[`EIP_ISC_MODE] = ctl_reg.levelMode;
            end
            `EIP_IDX_BRK: rdData[`EIP_BRK_CLREN] = ctl_reg.breakClrEn;
            `EIP_IDX_EVT: rdData[`EIP_EVT_W-1:0] = evtStat_reg;
            `EIP_IDX_EVM: rdData[`EIP_EVT_W-1:0] = evtMask_reg;
            default: rdHit = 1'b0;
        endcase
    end

    // one read in flight; data registered on the address handshake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `EIP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdData;
            s_axi_rresp   <= rdHit ? `EIP_RESP_OKAY : `EIP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************

    property p_ackReadsZero;
        @(posedge clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready && rdIdx == `EIP_IDX_ISC)
            |=> !s_axi_rdata[`EIP_ISC_ACK];
    endproperty
    a_ackReadsZero: assert property (p_ackReadsZero)
        else $error("acknowledge bit read back as one");

    property p_pendReadsLatch;
        @(posedge clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready && rdIdx == `EIP_IDX_ISC)
            |=> s_axi_rdata[`EIP_ISC_PEND] == $past(latch_reg);
    endproperty
    a_pendReadsLatch: assert property (p_pendReadsLatch)
        else $error("pending flag differs from latch");

    property p_edgeSets;
        @(posedge clk) disable iff (rst)
        (ctl_reg.funcEn && pinSync2_reg ##1 ctl_reg.funcEn && !pinSync2_reg)
            |=> latch_reg;
    endproperty
    a_edgeSets: assert property (p_edgeSets)
        else $error("falling edge did not set latch");

    property p_maskHolds;
        @(posedge clk) disable iff (rst)
        cpuIrqReq |-> $past(latch_reg) && !$past(ctl_reg.reqMask);
    endproperty
    a_maskHolds: assert property (p_maskHolds)
        else $error("request passed while masked or idle");

    property p_edgeAckClears;
        @(posedge clk) disable iff (rst)
        (latch_reg && anyAck && !ctl_reg.levelMode && !fallEdge)
            |=> !latch_reg;
    endproperty
    a_edgeAckClears: assert property (p_edgeAckClears)
        else $error("edge mode ack did not clear latch");

    property p_levelLowHolds;
        @(posedge clk) disable iff (rst)
        (ctl_reg.levelMode && !effLvl) |=> latch_reg;
    endproperty
    a_levelLowHolds: assert property (p_levelLowHolds)
        else $error("level mode latch dropped while pin low");

    property p_breakProtect;
        @(posedge clk) disable iff (rst)
        (latch_reg && swAckReq && breakState && !ctl_reg.breakClrEn
            && !vectorFetch && !ackSeen_reg) |=> latch_reg;
    endproperty
    a_breakProtect: assert property (p_breakProtect)
        else $error("ack cleared latch during protected break");

    property p_disabledBranchHigh;
        @(posedge clk) disable iff (rst)
        !ctl_reg.funcEn |=> branchPinLevel && (!latch_reg || $past(latch_reg));
    endproperty
    a_disabledBranchHigh: assert property (p_disabledBranchHigh)
        else $error("branch level low with function disabled");

    property p_pullupFollows;
        @(posedge clk) disable iff (rst)
        ##1 pullupEnable == !$past(ctl_reg.pullupDis);
    endproperty
    a_pullupFollows: assert property (p_pullupFollows)
        else $error("pullup does not follow disable bit");

endmodule : eip_top

// ===== eip_partner.sv
// model of the interrupt source on the pin and of the cpu vector fetch
`timescale 1ns/1ps

module eip_partner (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic drvLow,
    input  wire logic autoFetch,
    input  wire logic pullupEnable,
    input  wire logic cpuIrqReq,
    output logic      extIntPin_n,
    output logic      vectorFetch
);
    // ************************************************
    // pin source
    // ************************************************
    logic [2:0] holdOff;

    // released pin with no pullup floats: show a changing level, not a 1
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extIntPin_n <= 1'b1;
        end else begin
            extIntPin_n <= drvLow ? 1'b0 : (pullupEnable | ~extIntPin_n);
        end
    end

    // ************************************************
    // cpu vector fetch
    // ************************************************
    // one fetch per taken request; hold-off covers the request's fall time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vectorFetch <= 1'b0;
            holdOff     <= 3'h0;
        end else begin
            vectorFetch <= 1'b0;
            if (holdOff != 3'h0) begin
                holdOff <= holdOff - 3'h1;
            end else if (autoFetch && cpuIrqReq) begin
                vectorFetch <= 1'b1;
                holdOff     <= 3'h5;
            end
        end
    end
endmodule : eip_partner

// ===== eip_top_bench.sv
// self-checking bench for the external interrupt pin block
`timescale 1ns/1ps
`include "eip_cfg.svh"

module eip_top_bench;
    // ************************************************
    // signals
    // ************************************************
    localparam logic [7:0] aOpt = {`EIP_IDX_OPT2, 2'b00};
    localparam logic [7:0] aIsc = {`EIP_IDX_ISC, 2'b00};
    localparam logic [7:0] aBrk = {`EIP_IDX_BRK, 2'b00};
    localparam logic [7:0] aEvt = {`EIP_IDX_EVT, 2'b00};
    localparam logic [7:0] aEvm = {`EIP_IDX_EVM, 2'b00};
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr;
    logic        pinN, fetch, brk, drvLow, autoFetch;
    logic        irqReq, brLvl, puEn, isInt, irqOut;
    logic [15:0] vecAddr;
    int          mismatches, comparisons;

    eip_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .extIntPin_n(pinN), .vectorFetch(fetch),
        .breakState(brk), .cpuIrqReq(irqReq), .vectorAddr(vecAddr),
        .branchPinLevel(brLvl), .pullupEnable(puEn),
        .pinIsIntFunction(isInt), .irqOut(irqOut));

    eip_partner far (.clk(clk), .rst(rst), .drvLow(drvLow),
        .autoFetch(autoFetch), .pullupEnable(puEn), .cpuIrqReq(irqReq),
        .extIntPin_n(pinN), .vectorFetch(fetch));

    // ************************************************
    // tasks
    // ************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("counts: %0d compared, %0d wrong", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        bready <= 1'b0;
        check({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
    endtask : wr

    task automatic rdReg(input logic [7:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        rd = rvalid ? rdata : 32'hDEAD_BEEF;
        rr = rresp;
        rready <= 1'b0;
    endtask : rdReg

    task automatic expPend(input logic e);
        rdReg(aIsc);
        check({31'h0, rd[`EIP_ISC_PEND]}, {31'h0, e});
    endtask : expPend

    // pin path needs 5 edges to reach the request; 6 leaves margin
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask : settle

    // ************************************************
    // clock, watchdog, sequence
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // expected run is a few hundred cycles
    initial begin
        #400000;
        mismatches++;
        results();
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h21;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {brk, drvLow, autoFetch} = 3'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // reset state and unmapped places
        rdReg(aOpt);
        check(rd, 32'h0);
        rdReg(aIsc);
        check(rd, 32'h0);
        check({puEn, brLvl, isInt, irqReq}, 32'hC);
        rdReg(8'h40);
        check(rd, 32'h0);
        check({30'h0, rr}, {30'h0, `EIP_RESP_SLVERR});
        wr(8'h40, 32'h1, `EIP_RESP_SLVERR);
        $display("test reset done");
        // function disabled: pin ignored, branch sees one
        drvLow <= 1'b1;
        settle();
        expPend(1'b0);
        check(brLvl, 1'b1);
        drvLow <= 1'b0;
        settle();
        // edge mode, software acknowledge, new edge after it
        wr(aOpt, 32'h1, `EIP_RESP_OKAY);
        @(posedge clk);
        check(isInt, 1'b1);
        drvLow <= 1'b1;
        settle();
        expPend(1'b1);
        check({irqReq, brLvl}, 2'h2);
        wr(aIsc, 32'h4, `EIP_RESP_OKAY);
        rdReg(aIsc);
        check(rd, 32'h0);
        drvLow <= 1'b0;
        settle();
        drvLow <= 1'b1;
        settle();
        expPend(1'b1);
        $display("test edge done");
        // mask withholds request, flag still visible; fetch acknowledges
        wr(aIsc, 32'h2, `EIP_RESP_OKAY);
        settle();
        check(irqReq, 1'b0);
        rdReg(aIsc);
        check(rd, 32'hA);
        wr(aIsc, 32'h0, `EIP_RESP_OKAY);
        autoFetch <= 1'b1;
        repeat (12) @(posedge clk);
        autoFetch <= 1'b0;
        check(vecAddr, `EIP_VEC_HI);
        expPend(1'b0);
        $display("test mask and fetch done");
        // level mode, handler keeps requests masked
        drvLow <= 1'b0;
        wr(aIsc, 32'h3, `EIP_RESP_OKAY);
        drvLow <= 1'b1;
        settle();
        expPend(1'b1);
        check(irqReq, 1'b0);
        wr(aIsc, 32'h7, `EIP_RESP_OKAY);
        settle();
        expPend(1'b1);
        drvLow <= 1'b0;
        settle();
        expPend(1'b0);
        drvLow <= 1'b1;
        settle();
        drvLow <= 1'b0;
        settle();
        expPend(1'b1);
        wr(aIsc, 32'h7, `EIP_RESP_OKAY);
        expPend(1'b0);
        $display("test level done");
        // reset in mid-run with pin held low
        drvLow <= 1'b1;
        settle();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdReg(aIsc);
        check(rd, 32'h0);
        drvLow <= 1'b0;
        wr(aOpt, 32'h1, `EIP_RESP_OKAY);
        // break state: acknowledge refused unless clear-enable set
        brk <= 1'b1;
        drvLow <= 1'b1;
        settle();
        wr(aIsc, 32'h4, `EIP_RESP_OKAY);
        expPend(1'b1);
        wr(aBrk, 32'h1, `EIP_RESP_OKAY);
        wr(aIsc, 32'h4, `EIP_RESP_OKAY);
        brk <= 1'b0;
        drvLow <= 1'b0;
        settle();
        expPend(1'b0);
        $display("test break done");
        // event status, mask and interrupt line
        rdReg(aEvt);
        check(rd, 32'h3);
        check(irqOut, 1'b0);
        wr(aEvm, 32'h1, `EIP_RESP_OKAY);
        repeat (2) @(posedge clk);
        check(irqOut, 1'b1);
        wr(aEvt, 32'h3, `EIP_RESP_OKAY);
        repeat (2) @(posedge clk);
        check(irqOut, 1'b0);
        rdReg(aEvt);
        check(rd, 32'h0);
        // pullup disable
        wr(aOpt, 32'h3, `EIP_RESP_OKAY);
        repeat (2) @(posedge clk);
        check(puEn, 1'b0);
        $display("test events and pullup done");
        results();
    end
endmodule : eip_top_bench
